// ==== verilog/mrb_boot_rom.sv ====
// Mode-select package and the small boot ROM array
package mrb_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int ALT_VEC_BIT = 14;
    localparam int ROM_BYTES = 192;
    localparam int ROM_BYTES_MAX = 448;
    localparam int ROM_IDX_W = 8;
    localparam logic [ADDR_W-1:0] ROM_BASE = 16'hbf40;
    localparam logic [ROM_IDX_W-1:0] RESET_VEC_HI_IDX = 8'hbe;
    localparam logic [ROM_IDX_W-1:0] RESET_VEC_LO_IDX = 8'hbf;
    localparam logic RESET_EXPANDED = 1'h0;
    localparam logic RESET_SPECIAL = 1'h0;
    localparam logic RESET_BOOT_EN = 1'h0;
    localparam logic [DATA_W-1:0] ROM_FILL = 8'h00;

    typedef enum logic [1:0] {
        MRB_NORMAL_SINGLE,
        MRB_NORMAL_EXPANDED,
        MRB_SPECIAL_BOOT,
        MRB_SPECIAL_TEST
    } mrb_mode_t;

    function automatic mrb_mode_t mrb_decode(input logic special, input logic expanded);
        mrb_mode_t m;
        m = MRB_NORMAL_SINGLE;
        unique case ({special, expanded})
            2'h0: m = MRB_NORMAL_SINGLE;
            2'h1: m = MRB_NORMAL_EXPANDED;
            2'h2: m = MRB_SPECIAL_BOOT;
            2'h3: m = MRB_SPECIAL_TEST;
        endcase
        return m;
    endfunction
endpackage

`timescale 1ns/1ns
`default_nettype none
module mrb_boot_rom (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_rd,
    input wire logic [mrb_pkg::ROM_IDX_W-1:0] i_idx,
    output logic [mrb_pkg::DATA_W-1:0] o_data
);
    import mrb_pkg::*;
    logic [DATA_W-1:0] mem [0:ROM_BYTES-1];
    logic [DATA_W-1:0] data_r;
    logic [DATA_W-1:0] data_nxt;

    // Only the reset vector is fixed; loader code is a separate image
    always_comb begin
        for (int k = 0; k < ROM_BYTES; k++) begin
            mem[k] = ROM_FILL;
        end
        mem[int'(RESET_VEC_HI_IDX)] = ROM_BASE[ADDR_W-1:DATA_W];
        mem[int'(RESET_VEC_LO_IDX)] = ROM_BASE[DATA_W-1:0];
    end

    always_comb begin
        data_nxt = data_r;
        if (i_rd && (int'(i_idx) < ROM_BYTES)) begin
            data_nxt = mem[i_idx];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            data_r <= ROM_FILL;
        end else begin
            data_r <= data_nxt;
        end
    end

    assign o_data = data_r;
endmodule // mrb_boot_rom
`default_nettype wire

// ==== verilog/mrb_mode_ctrl.sv ====
// Operating-mode latch, boot ROM mapping and alternate vector steering
// Operation
// - Strap A at release sets expanded select
// - Inverted strap B at release sets special
// - Two bits decode into four modes
// - Boot ROM mapped only while enable set
// - Enable resets to one only in bootstrap
// - Enable writable in special, forced zero otherwise
// - Mode bits writable while special is one
// - Special mode fetches vectors from BFxx page
// - Vector fetch in special drives A14 low
// - Bootstrap reset vector comes from boot ROM
// - Boot ROM holds 192 bytes here
// - Firmware stores program in RAM, jumps
`timescale 1ns/1ns
`default_nettype none
module mrb_mode_ctrl (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_strap_pin_a,
    input wire logic i_strap_pin_b,
    input wire logic i_wr_en,
    input wire logic i_wr_expanded,
    input wire logic i_wr_special,
    input wire logic i_wr_boot_en,
    input wire logic i_cpu_rd,
    input wire logic i_vector_fetch,
    input wire logic [mrb_pkg::ADDR_W-1:0] i_cpu_addr,
    output logic o_expanded_select_bit,
    output logic o_special_mode_bit,
    output logic o_boot_rom_enable,
    output mrb_pkg::mrb_mode_t o_mode,
    output logic o_strap_loaded,
    output logic [mrb_pkg::ADDR_W-1:0] o_bus_addr,
    output logic o_rom_sel,
    output logic [mrb_pkg::DATA_W-1:0] o_rom_data
);
    import mrb_pkg::*;

    // Straps are asynchronous pins; synchroniser runs through reset
    // so the pin level is already settled when the load edge comes
    localparam int N_STRAP = 2;
    logic [N_STRAP-1:0] pin_raw;
    logic [N_STRAP-1:0] pin_s1;
    logic [N_STRAP-1:0] pin_s2;
    logic pin_a_s2;
    logic pin_b_s2;
    assign pin_raw = {i_strap_pin_b, i_strap_pin_a};
    for (genvar g = 0; g < N_STRAP; g++) begin : g_sync
        always_ff @(posedge i_core_clk) begin
            pin_s1[g] <= pin_raw[g];
            pin_s2[g] <= pin_s1[g];
        end
    end
    assign pin_a_s2 = pin_s2[0];
    assign pin_b_s2 = pin_s2[1];

    logic first_r;
    logic first_nxt;
    logic expanded_r;
    logic expanded_nxt;
    logic special_r;
    logic special_nxt;
    logic boot_en_r;
    logic boot_en_nxt;
    mrb_mode_t strap_mode;

    always_comb begin
        first_nxt = 1'h0;
        expanded_nxt = expanded_r;
        special_nxt = special_r;
        boot_en_nxt = boot_en_r;
        strap_mode = mrb_decode(!pin_b_s2, pin_a_s2);
        if (first_r) begin
            expanded_nxt = pin_a_s2;
            special_nxt = !pin_b_s2;
            boot_en_nxt = (strap_mode == MRB_SPECIAL_BOOT);
        end else if (i_wr_en && special_r) begin
            // Permission follows the bit before this write takes effect
            expanded_nxt = i_wr_expanded;
            special_nxt = i_wr_special;
            boot_en_nxt = i_wr_boot_en;
        end
        if (!first_r && !special_nxt) begin
            boot_en_nxt = 1'h0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            first_r <= 1'h1;
            expanded_r <= RESET_EXPANDED;
            special_r <= RESET_SPECIAL;
            boot_en_r <= RESET_BOOT_EN;
        end else begin
            first_r <= first_nxt;
            expanded_r <= expanded_nxt;
            special_r <= special_nxt;
            boot_en_r <= boot_en_nxt;
        end
    end

    // Address path: one registered stage so outputs leave flops
    logic [ADDR_W-1:0] eff_addr;
    logic rom_hit;
    logic [ADDR_W-1:0] bus_addr_r;
    logic [ADDR_W-1:0] bus_addr_nxt;
    logic rom_sel_r;
    logic rom_sel_nxt;
    logic [ADDR_W-1:0] rom_off;

    // Upper bound matters: without it the ROM would alias over C000-FFFF
    function automatic logic in_rom_window(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - ROM_BASE;
        return (a >= ROM_BASE) && (off < ADDR_W'(ROM_BYTES));
    endfunction

    always_comb begin
        eff_addr = i_cpu_addr;
        if (i_vector_fetch && special_r) begin
            eff_addr[ALT_VEC_BIT] = 1'h0;
        end
        rom_off = eff_addr - ROM_BASE;
        rom_hit = i_cpu_rd && boot_en_r && in_rom_window(eff_addr);
        bus_addr_nxt = i_cpu_rd ? eff_addr : bus_addr_r;
        rom_sel_nxt = rom_hit;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            bus_addr_r <= '0;
            rom_sel_r <= 1'h0;
        end else begin
            bus_addr_r <= bus_addr_nxt;
            rom_sel_r <= rom_sel_nxt;
        end
    end

    mrb_boot_rom u_rom (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_rd(rom_hit),
        .i_idx(rom_off[ROM_IDX_W-1:0]),
        .o_data(o_rom_data)
    );

    assign o_expanded_select_bit = expanded_r;
    assign o_special_mode_bit = special_r;
    assign o_boot_rom_enable = boot_en_r;
    assign o_mode = mrb_decode(special_r, expanded_r);
    assign o_strap_loaded = !first_r;
    assign o_bus_addr = bus_addr_r;
    assign o_rom_sel = rom_sel_r;

    // Baud pick, RAM load and jump are loader code from a separate image, not this ROM array
    // Hardware only has to hand that code the reset vector

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_strap_a_load: assert property (i_rst_n && first_r |=> expanded_r == $past(pin_a_s2))
        else $error("expanded bit not taken from strap A");
    a_strap_b_load: assert property (i_rst_n && first_r |=> special_r == !$past(pin_b_s2))
        else $error("special bit not inverse of strap B");
    a_mode_decode: assert property ((o_mode == MRB_SPECIAL_TEST) == (special_r && expanded_r))
        else $error("mode decode wrong");
    a_mode_boot: assert property ((o_mode == MRB_SPECIAL_BOOT) == (special_r && !expanded_r))
        else $error("bootstrap mode decode wrong");
    a_rom_visible: assert property (o_rom_sel |-> $past(boot_en_r) && $past(i_cpu_rd))
        else $error("boot ROM selected while disabled");
    a_boot_reset_val: assert property (i_rst_n && first_r |=>
        boot_en_r == (!$past(pin_b_s2) && !$past(pin_a_s2)))
        else $error("boot enable reset value wrong");
    a_boot_normal_zero: assert property (!first_r && !special_r |-> !boot_en_r)
        else $error("boot enable set in normal mode");
    a_mode_locked: assert property (!first_r && !special_r |=> $stable(expanded_r) && !special_r)
        else $error("mode bits changed in normal mode");
    a_vector_a14: assert property (i_cpu_rd && i_vector_fetch && special_r |=> !o_bus_addr[ALT_VEC_BIT])
        else $error("A14 not low on special vector fetch");
    a_strap_hold: assert property (!first_r && !i_wr_en |=> $stable(expanded_r) && $stable(special_r))
        else $error("mode bits changed without write");
    a_strap_loaded: assert property (i_rst_n && first_r |=> o_strap_loaded)
        else $error("strap load flag not raised");
    a_first_once: assert property (!first_r |=> !first_r)
        else $error("straps sampled again without reset");

    // Write privilege checks
    a_boot_write: assert property (i_wr_en && !first_r && special_r && i_wr_special |=>
        boot_en_r == $past(i_wr_boot_en))
        else $error("boot enable write lost in special mode");
    a_boot_cleared: assert property (i_wr_en && !first_r && special_r && !i_wr_special |=>
        !boot_en_r && !special_r)
        else $error("boot enable kept after leaving special mode");
    a_mode_write: assert property (i_wr_en && !first_r && special_r |=>
        expanded_r == $past(i_wr_expanded) && special_r == $past(i_wr_special))
        else $error("mode bit write lost in special mode");

    // Address and ROM checks
    a_rom_window: assert property (o_rom_sel |-> in_rom_window(o_bus_addr))
        else $error("boot ROM selected outside its window");
    a_rom_vector_hi: assert property (o_rom_sel && o_bus_addr == ROM_BASE + ADDR_W'(RESET_VEC_HI_IDX) |->
        o_rom_data == ROM_BASE[ADDR_W-1:DATA_W])
        else $error("boot ROM reset vector high byte wrong");
    a_plain_read: assert property (i_cpu_rd && !i_vector_fetch |=> o_bus_addr == $past(i_cpu_addr))
        else $error("address changed on a plain read");
    a_normal_vector: assert property (i_cpu_rd && !special_r |=> o_bus_addr == $past(i_cpu_addr))
        else $error("vector page moved in normal mode");
    a_data_hold: assert property (!rom_hit |=> $stable(o_rom_data))
        else $error("ROM data changed without a hit");
    a_bus_addr_hold: assert property (!i_cpu_rd |=> $stable(o_bus_addr))
        else $error("bus address changed without a read");

    c_boot_mode: cover property (first_r ##1 o_mode == MRB_SPECIAL_BOOT);
    c_boot_vector: cover property (o_mode == MRB_SPECIAL_BOOT && i_cpu_rd && i_vector_fetch ##1 o_rom_sel);
    c_to_expanded: cover property (o_mode == MRB_SPECIAL_BOOT ##1 i_wr_en && i_wr_expanded ##1 expanded_r);
    c_test_mode: cover property (first_r ##1 o_mode == MRB_SPECIAL_TEST);
    c_normal_write: cover property (o_mode == MRB_NORMAL_EXPANDED && i_wr_en);
endmodule // mrb_mode_ctrl
`default_nettype wire

// ==== test/mrb_strap_model.sv ====
// Board strap model: drives the two mode pins around reset
`timescale 1ns/1ns
`default_nettype none
module mrb_strap_model (
    input wire logic i_core_clk,
    input wire logic i_hold,
    input wire logic [1:0] i_code,
    output logic o_strap_pin_a,
    output logic o_strap_pin_b
);
    logic flip_r = 1'b0;
    // Once released the pins wander every cycle, so any resampling shows up
    always_ff @(posedge i_core_clk) flip_r <= ~flip_r;
    assign o_strap_pin_a = i_hold ? i_code[0] : flip_r;
    assign o_strap_pin_b = i_hold ? i_code[1] : ~flip_r;
endmodule // mrb_strap_model
`default_nettype wire

// ==== test/mrb_mode_ctrl_test.sv ====
// Self-checking bench for the mode latch and boot ROM steering
`timescale 1ns/1ns
`default_nettype none
module mrb_mode_ctrl_test;
    import mrb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hold = 1'b1;
    logic [1:0] code = 2'h0;
    logic pa, pb, o_x, o_s, o_b, o_ld, o_sel;
    logic wr_en = 1'b0, wr_x = 1'b0, wr_s = 1'b0, wr_b = 1'b0, rd = 1'b0, vec = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] o_addr;
    logic [7:0] o_dat;
    mrb_mode_t o_md;
    int err_count = 0;
    int n_tests = 0;
    int seed = 82;
    int ex, es, eb, r;
    always #5 clk = ~clk;
    mrb_strap_model strap (.i_core_clk(clk), .i_hold(hold), .i_code(code),
        .o_strap_pin_a(pa), .o_strap_pin_b(pb));
    mrb_mode_ctrl dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_strap_pin_a(pa),
        .i_strap_pin_b(pb), .i_wr_en(wr_en), .i_wr_expanded(wr_x), .i_wr_special(wr_s),
        .i_wr_boot_en(wr_b), .i_cpu_rd(rd), .i_vector_fetch(vec), .i_cpu_addr(addr),
        .o_expanded_select_bit(o_x), .o_special_mode_bit(o_s), .o_boot_rom_enable(o_b),
        .o_mode(o_md), .o_strap_loaded(o_ld), .o_bus_addr(o_addr), .o_rom_sel(o_sel),
        .o_rom_data(o_dat));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check_bits();
        check("expanded", 16'(o_x), 16'(ex));
        check("special", 16'(o_s), 16'(es));
        check("boot_en", 16'(o_b), 16'(eb));
        check("mode", 16'(o_md), 16'(es * 2 + ex));
    endtask
    task automatic vec_read();
        @(posedge clk);
        rd <= 1'b1;
        vec <= 1'b1;
        addr <= 16'hfffe;
        @(posedge clk);
        rd <= 1'b0;
        vec <= 1'b0;
        #1;
        check("bus_addr", o_addr, (es == 1) ? 16'hbffe : 16'hfffe);
        check("rom_sel", 16'(o_sel), 16'(eb));
        if (eb == 1) check("rom_data", 16'(o_dat), 16'h00bf);
    endtask
    task automatic plain_read();
        @(posedge clk);
        rd <= 1'b1;
        addr <= 16'hfffe;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("plain_addr", o_addr, 16'hfffe);
        check("plain_sel", 16'(o_sel), 16'h0000);
    endtask
    // No serial link here: the host's leading FF for baud pick is outside this block
    initial begin
        // Each strap code gets a fresh reset, so reset also lands mid-run
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            rst_n <= 1'b0;
            hold <= 1'b1;
            code <= 2'(i);
            repeat (10) @(posedge clk);
            rst_n <= 1'b1;
            ex = i % 2;
            es = 1 - i / 2;
            eb = (es == 1 && ex == 0) ? 1 : 0;
            repeat (2) @(posedge clk);
            hold <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            check_bits();
            check("loaded", 16'(o_ld), 16'h0001);
            vec_read();
            plain_read();
            repeat (2) begin
                r = $random(seed);
                @(posedge clk);
                wr_en <= 1'b1;
                wr_x <= r[0];
                wr_s <= r[1];
                wr_b <= r[2];
                @(posedge clk);
                wr_en <= 1'b0;
                #1;
                if (es == 1) begin
                    ex = r[0];
                    es = r[1];
                    eb = r[2] & r[1];
                end
                check_bits();
                vec_read();
            end
        end
        close_out();
    end
endmodule // mrb_mode_ctrl_test
`default_nettype wire
